// ==== fsa_fault_status_aggregator.sv ====
// fault flag latching, fault index summary and alert pin drive
`timescale 1ns/1ps
`default_nettype none
module fsa_fault_status_aggregator
	import fsa_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] warnDetect,
	input  wire logic       boostMode,
	input  wire logic [5:0] otherPending,
	input  wire logic       clearAllCmd,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWData,
	output logic [7:0]      regRData,
	output logic            regRValid,
	output logic            faultAlertOut,
	output logic            faultAlertOe
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] index;
		logic       protect;
		logic [7:0] rdata;
		logic       rvalid;
		logic       alertOe;
		logic       alertLvl;
	} fsa_state_s;

	fsa_state_s st;
	fsa_state_s next_st;

	logic [FSA_SYNC_WIDTH-1:0] syncIn;
	logic [FSA_SYNC_WIDTH-1:0] syncOut;
	logic [7:0]                detSync;
	logic                      boostSync;
	logic [7:0]                setMask;
	logic [7:0]                clrMask;
	logic                      writeOpen;
	logic                      flagsWrite;

	// ****************************************************************
	// detector inputs are analog-side levels, so resync them
	// ****************************************************************
	assign syncIn = {boostMode, warnDetect};

	fsa_sync #(
		.WIDTH (FSA_SYNC_WIDTH)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (syncIn),
		.syncOut (syncOut)
	);

	assign detSync   = syncOut[7:0];
	assign boostSync = syncOut[8];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_st    = st;
		writeOpen  = !st.protect;
		flagsWrite = regWrite && (regAddr == FSA_OFF_FLAGS);

		setMask = detSync;
		// low-bus input overvoltage only counts in boost direction
		setMask[FSA_LOWBUS_IN_OV] = detSync[FSA_LOWBUS_IN_OV] && boostSync;

		clrMask = 8'h00;
		if (writeOpen && clearAllCmd) begin
			clrMask = 8'hFF;
		end
		// write-back clears only bits whose value matches the written one
		if (writeOpen && flagsWrite) begin
			clrMask = clrMask | (regWData & st.flags);
		end
		// set beats clear so a fault in the clear cycle survives
		next_st.flags = (st.flags & ~clrMask) | setMask;

		// protect register stays writable even while protected
		if (regWrite && (regAddr == FSA_OFF_PROTECT)) begin
			next_st.protect = regWData[FSA_PROTECT_BIT];
		end

		next_st.index[0]   = |next_st.flags;
		next_st.index[6:1] = otherPending;
		next_st.index[FSA_SUMMARY_BIT] = |next_st.index[6:0];
		next_st.alertOe    = |next_st.index[6:0];
		// open-drain pin: level stays low, only the enable moves
		next_st.alertLvl   = 1'b0;

		next_st.rvalid = regRead;
		if (regRead) begin
			case (regAddr)
				FSA_OFF_PROTECT: next_st.rdata = {st.protect, 7'h00};
				FSA_OFF_INDEX:   next_st.rdata = st.index;
				FSA_OFF_FLAGS:   next_st.rdata = st.flags;
				default:         next_st.rdata = FSA_UNMAPPED_READ;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.flags   <= FSA_FLAGS_RESET;
			st.index   <= FSA_INDEX_RESET;
			st.protect <= FSA_PROTECT_RESET;
			st.rdata   <= 8'h00;
			st.rvalid  <= 1'b0;
			st.alertOe <= 1'b0;
			st.alertLvl <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign faultAlertOut = st.alertLvl;
	assign regRData     = st.rdata;
	assign regRValid    = st.rvalid;
	assign faultAlertOe = st.alertOe;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_alert_on_flag: assert property (
		(|st.flags) |-> faultAlertOe)
		else $error("flag set but alert pin released");

	a_read_any_time: assert property (
		regRead && (regAddr == FSA_OFF_FLAGS)
		|=> regRValid && (regRData == $past(st.flags)))
		else $error("status read not answered with flags");

	a_flag_sticky: assert property (
		!clearAllCmd && !flagsWrite
		|=> ((st.flags & $past(st.flags)) == $past(st.flags)))
		else $error("flag dropped without clear");

	a_protect_holds: assert property (
		st.protect && !(regWrite && (regAddr == FSA_OFF_PROTECT))
		|=> ((st.flags & $past(st.flags)) == $past(st.flags)))
		else $error("flag cleared while writes protected");

	a_clear_all: assert property (
		!st.protect && clearAllCmd |=> (st.flags == $past(setMask)))
		else $error("clear-all left stale flags");

	a_index_bits: assert property (
		st.index[6:0] == {$past(otherPending), |st.flags})
		else $error("index bits disagree with status");

	// summary checked against the sources, not against the alert enable
	a_summary_bit: assert property (
		st.index[FSA_SUMMARY_BIT] == ((|st.flags) || (|$past(otherPending))))
		else $error("summary bit disagrees with pending faults");

	a_detect_alert: assert property (
		(|setMask) |=> faultAlertOe)
		else $error("detected fault did not pull the alert");

	a_flag_capture: assert property (
		(|setMask) |=> ((st.flags & $past(setMask)) == $past(setMask)))
		else $error("detected fault not latched");

	a_boost_only: assert property (
		$rose(st.flags[FSA_LOWBUS_IN_OV])
		|-> $past(detSync[FSA_LOWBUS_IN_OV] && boostSync))
		else $error("low-bus input overvoltage set outside boost");

	a_protect_write: assert property (
		regWrite && (regAddr == FSA_OFF_PROTECT)
		|=> st.protect == $past(regWData[FSA_PROTECT_BIT]))
		else $error("protect bit not written");

	a_alert_release: assert property (
		(st.flags == 8'h00) && ($past(otherPending) == 6'h00)
		|-> !faultAlertOe && !st.index[FSA_SUMMARY_BIT])
		else $error("alert held with nothing pending");

	a_rvalid_source: assert property (
		regRValid |-> $past(regRead))
		else $error("read answer without a read");

	a_unmapped_read: assert property (
		regRead && (regAddr != FSA_OFF_PROTECT)
		&& (regAddr != FSA_OFF_INDEX) && (regAddr != FSA_OFF_FLAGS)
		|=> (regRData == FSA_UNMAPPED_READ))
		else $error("unmapped read not answered with default");

	c_fault_alert: cover property ($rose(faultAlertOe));
	c_clear_release: cover property (
		faultAlertOe && clearAllCmd && !st.protect ##1 !faultAlertOe);
	c_blocked_clear: cover property (st.protect && clearAllCmd && |st.flags);
	c_writeback: cover property (flagsWrite && !st.protect && |st.flags);
	c_other_alert: cover property (
		(|otherPending) && (st.flags == 8'h00) ##1 faultAlertOe);

endmodule : fsa_fault_status_aggregator
`default_nettype wire

// ==== fsa_pkg.sv ====
// constants shared by the fault status aggregator
package fsa_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] FSA_OFF_PROTECT = 8'h10;
	localparam logic [7:0] FSA_OFF_INDEX   = 8'hC0;
	localparam logic [7:0] FSA_OFF_FLAGS   = 8'hD2;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int         FSA_PROTECT_BIT   = 7;
	localparam int         FSA_SUMMARY_BIT   = 7;
	localparam int         FSA_LOWBUS_IN_OV  = 2;
	localparam int         FSA_OTHER_REGS    = 6;
	localparam int         FSA_SYNC_WIDTH    = 9;
	localparam logic [7:0] FSA_FLAGS_RESET   = 8'h00;
	localparam logic [7:0] FSA_INDEX_RESET   = 8'h00;
	localparam logic       FSA_PROTECT_RESET = 1'b0;
	localparam logic [7:0] FSA_UNMAPPED_READ = 8'h00;

endpackage : fsa_pkg

// ==== fsa_sync.sv ====
// two-stage synchroniser, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module fsa_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;

	// ****************************************************************
	// per-bit flop pair
	// ****************************************************************
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_lane
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1[i]  <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					stage1[i]  <= asyncIn[i];
					syncOut[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule : fsa_sync
`default_nettype wire

// ==== fsa_mcu_model.sv ====
// microcontroller model on the register port
`timescale 1ns/1ps
`default_nettype none
module fsa_mcu_model (
	input  wire logic       clk,
	input  wire logic [7:0] regRData,
	input  wire logic       regRValid,
	output var  logic       regRead,
	output var  logic       regWrite,
	output var  logic       clearAllCmd,
	output var  logic [7:0] regAddr,
	output var  logic [7:0] regWData
);
	initial begin
		regRead = 1'b0;
		regWrite = 1'b0;
		clearAllCmd = 1'b0;
		regAddr = 8'h00;
		regWData = 8'h00;
	end
	// released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		regAddr = ~a;
		regWData = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		regAddr = ~a;
		ok = regRValid;
		d = regRData;
	endtask : rd
	task automatic clr();
		@(negedge clk);
		clearAllCmd = 1'b1;
		@(negedge clk);
		clearAllCmd = 1'b0;
	endtask : clr
endmodule : fsa_mcu_model
`default_nettype wire

// ==== test_fault_status_aggregator.sv ====
// testbench of the fault status aggregator
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_aggregator import fsa_pkg::*;;
	logic        clk, rst_n, boostMode, clearAllCmd, regWrite, regRead;
	logic        regRValid, faultAlertOut, faultAlertOe;
	logic [7:0]  warnDetect, regAddr, regWData, regRData;
	logic [5:0]  otherPending;
	logic [31:0] seed = 32'h0000004D;
	int          n_fail = 0;
	int          n_tests = 0;
	fsa_fault_status_aggregator DUT (.clk(clk), .rst_n(rst_n),
		.warnDetect(warnDetect), .boostMode(boostMode),
		.otherPending(otherPending), .clearAllCmd(clearAllCmd),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWData(regWData), .regRData(regRData), .regRValid(regRValid),
		.faultAlertOut(faultAlertOut), .faultAlertOe(faultAlertOe));
	fsa_mcu_model mcu (.clk(clk), .regRData(regRData),
		.regRValid(regRValid), .regRead(regRead), .regWrite(regWrite),
		.clearAllCmd(clearAllCmd), .regAddr(regAddr), .regWData(regWData));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [7:0] expIdx(input logic [7:0] f,
		input logic [5:0] o);
		return {(|f) | (|o), o, |f};
	endfunction : expIdx
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		mcu.rd(a, d, ok);
		chk("read valid", 8'h01, {7'h00, ok});
		chk($sformatf("reg %h", a), e, d);
	endtask : rdChk
	// open-drain pin with pull-up: high unless driven
	task automatic pinChk(input logic e);
		chk("alert pin", {7'h00, e},
			{7'h00, faultAlertOe ? faultAlertOut : 1'b1});
	endtask : pinChk
	task automatic final_report();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		logic [7:0] r, f, v;
		logic       b;
		rst_n = 1'b0;
		warnDetect = 8'h00;
		boostMode = 1'b0;
		otherPending = 6'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		rdChk(FSA_OFF_PROTECT, 8'h00);
		rdChk(FSA_OFF_INDEX, FSA_INDEX_RESET);
		rdChk(8'h55, FSA_UNMAPPED_READ);
		for (int i = 0; i < 12; i++) begin
			r = (i == 0) ? 8'h04 : (i == 1) ? 8'hFF : 8'(xs());
			b = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'(xs());
			@(negedge clk);
			warnDetect = r;
			boostMode = b;
			repeat (4) @(negedge clk);
			warnDetect = 8'h00;
			f = r & ~{5'h00, ~b, 2'h0};
			pinChk(~|f);
			rdChk(FSA_OFF_INDEX, expIdx(f, 6'h00));
			rdChk(FSA_OFF_FLAGS, f);
			mcu.wr(FSA_OFF_PROTECT, 8'h80);
			mcu.wr(FSA_OFF_FLAGS, f);
			mcu.clr();
			mcu.wr(FSA_OFF_INDEX, 8'hFF);
			rdChk(FSA_OFF_PROTECT, 8'h80);
			rdChk(FSA_OFF_FLAGS, f);
			mcu.wr(FSA_OFF_PROTECT, 8'h00);
			v = f & 8'(xs());
			mcu.wr(FSA_OFF_FLAGS, v);
			rdChk(FSA_OFF_FLAGS, f & ~v);
			mcu.clr();
			rdChk(FSA_OFF_INDEX, 8'h00);
			pinChk(1'b1);
		end
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			otherPending = 6'h01 << i;
			@(negedge clk);
			pinChk(1'b0);
			rdChk(FSA_OFF_INDEX, expIdx(8'h00, otherPending));
			otherPending = 6'h00;
			@(negedge clk);
			pinChk(1'b1);
		end
		final_report();
	end
endmodule : test_fault_status_aggregator
`default_nettype wire
